// file: rtl/lofc_ctrl.sv
// open-loop fallback control with avalon-mm register slave
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "lofc_defines.svh"

// What this block does
// - with fallback enabled, switch closed loop to open loop after configured detection failures.
// - fallback open loop always drives square, ignoring the waveform select bit.
// - miss count field bits 6-5 selects three, four, five or six failed attempts.
// - user open loop drives square for select 0, sine for 1; select resets 0.
// - open-loop drive period equals the 10-bit period times a fixed time unit.
// - period upper two bits in high register bits 1-0, low eight bits next; reset 198.
// - read-only 8-bit impedance coefficient, reset 0, for use with the diagnostic result.
module lofc_ctrl #(
	parameter int PERIOD_W = 10 // width of the open-loop period
) (
	input wire logic i_sys_clk, // system clock, 10 MHz
	input wire logic i_rstn, // asynchronous reset, active low
	input wire logic [7:0] i_avs_address, // byte address
	input wire logic i_avs_read, // read request
	input wire logic i_avs_write, // write request
	input wire logic [31:0] i_avs_writedata, // write data
	input wire logic [3:0] i_avs_byteenable, // byte lanes
	output logic [31:0] o_avs_readdata, // read data
	output logic o_avs_waitrequest, // slave stall
	input wire logic i_open_loop_req, // user asks for open-loop drive
	input wire logic i_zc_attempt, // pulse: one detection attempt finished
	input wire logic i_zc_ok, // with attempt: crossing was detected
	input wire logic i_drive_stop, // pulse: drive ended, leave fallback
	input wire logic [7:0] i_coef_value, // coefficient from trim logic
	input wire logic i_coef_load, // pulse: load coefficient
	output logic o_open_loop, // open-loop drive active
	output logic o_sine, // open-loop shape is sine
	output logic o_fallback, // fallback took over
	output logic o_period_tick // one pulse per open-loop period
);

	////////////////////////////////////////////////////////////////////////
	// register state
	logic [7:0] fb_ctrl;
	logic [7:0] per_high;
	logic [7:0] per_low;
	logic [7:0] imp_coef;
	logic [7:0] next_fb_ctrl;
	logic [7:0] next_per_high;
	logic [7:0] next_per_low;
	logic [7:0] next_imp_coef;
	logic [31:0] next_readdata;
	logic next_waitrequest;
	logic ack;
	logic next_ack;

	// byte address from a word index
	function automatic logic [7:0] word_addr(input logic [7:0] idx);
		word_addr = {idx[5:0], 2'b00};
	endfunction

	// fallback attempts from field value
	function automatic logic [2:0] miss_limit(input logic [1:0] fld);
		miss_limit = `LOFC_MISS_BASE + {1'b0, fld};
	endfunction

	// one wait cycle per access keeps read data registered, answer in second cycle
	always_comb begin
		next_fb_ctrl = fb_ctrl;
		next_per_high = per_high;
		next_per_low = per_low;
		next_imp_coef = imp_coef;
		next_readdata = 32'h0000_0000;
		next_waitrequest = 1'b1;
		next_ack = 1'b0;
		if ((i_avs_read || i_avs_write) && o_avs_waitrequest && !ack) begin
			next_waitrequest = 1'b0;
			next_ack = 1'b1; // blocks a second answer while master releases
			if (i_avs_read) begin
				case (i_avs_address)
					word_addr(`LOFC_IDX_FALLBACK_CTRL): next_readdata = {24'h00_0000, fb_ctrl};
					word_addr(`LOFC_IDX_PERIOD_HIGH): next_readdata = {24'h00_0000, per_high};
					word_addr(`LOFC_IDX_PERIOD_LOW): next_readdata = {24'h00_0000, per_low};
					word_addr(`LOFC_IDX_IMP_COEF): next_readdata = {24'h00_0000, imp_coef};
					default: next_readdata = 32'h0000_0000;
				endcase
			end
		end
		// a write lands only at the edge where the master sees waitrequest low,
		// so the register and the completed transfer can never disagree
		if (i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]) begin
			if (i_avs_address == word_addr(`LOFC_IDX_FALLBACK_CTRL))
				next_fb_ctrl = i_avs_writedata[7:0];
			if (i_avs_address == word_addr(`LOFC_IDX_PERIOD_HIGH))
				next_per_high = {6'h00, i_avs_writedata[1:0]};
			if (i_avs_address == word_addr(`LOFC_IDX_PERIOD_LOW))
				next_per_low = i_avs_writedata[7:0];
		end
		// trim side is the only writer; the bus has no path into the coefficient
		if (i_coef_load)
			next_imp_coef = i_coef_value;
	end

	// register bank
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			fb_ctrl <= `LOFC_RST_FALLBACK_CTRL;
			per_high <= `LOFC_RST_PERIOD_HIGH;
			per_low <= `LOFC_RST_PERIOD_LOW;
			imp_coef <= `LOFC_RST_IMP_COEF;
			o_avs_readdata <= 32'h0000_0000;
			o_avs_waitrequest <= 1'b1;
			ack <= 1'b0;
		end else begin
			fb_ctrl <= next_fb_ctrl;
			per_high <= next_per_high;
			per_low <= next_per_low;
			imp_coef <= next_imp_coef;
			o_avs_readdata <= next_readdata;
			o_avs_waitrequest <= next_waitrequest;
			ack <= next_ack;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// fallback state machine
	lofc_pkg::lofc_mode_t mode;
	lofc_pkg::lofc_mode_t next_mode;
	logic [2:0] miss_cnt;
	logic [2:0] next_miss_cnt;
	logic fb_en;
	logic [2:0] limit;
	logic next_open_loop;
	logic next_fallback;
	logic next_sine;

	assign fb_en = fb_ctrl[`LOFC_FB_ENABLE_BIT];
	assign limit = miss_limit(fb_ctrl[`LOFC_MISS_CNT_HI:`LOFC_MISS_CNT_LO]);

	// consecutive misses drive fallback; fallback holds until drive stops or the enable clears
	always_comb begin
		next_mode = mode;
		next_miss_cnt = miss_cnt;
		case (mode)
			lofc_pkg::LOFC_CLOSED: begin
				if (i_open_loop_req)
					next_mode = lofc_pkg::LOFC_OPEN_USER;
				else if (i_zc_attempt && i_zc_ok)
					next_miss_cnt = 3'h0;
				else if (i_zc_attempt && fb_en) begin
					if (miss_cnt + 3'h1 >= limit) begin
						next_mode = lofc_pkg::LOFC_OPEN_FALLBACK;
						next_miss_cnt = 3'h0;
					end else
						next_miss_cnt = miss_cnt + 3'h1;
				end
				if (!fb_en)
					next_miss_cnt = 3'h0;
			end
			lofc_pkg::LOFC_OPEN_USER: begin
				if (!i_open_loop_req)
					next_mode = lofc_pkg::LOFC_CLOSED;
			end
			lofc_pkg::LOFC_OPEN_FALLBACK: begin
				if (i_drive_stop || !fb_en)
					next_mode = lofc_pkg::LOFC_CLOSED;
			end
			default: next_mode = lofc_pkg::LOFC_CLOSED;
		endcase
		// outputs follow the next mode so they change with it, not a cycle later
		next_open_loop = (next_mode != lofc_pkg::LOFC_CLOSED);
		next_fallback = (next_mode == lofc_pkg::LOFC_OPEN_FALLBACK);
		// fallback forces square whatever the select bit says
		next_sine = (next_mode == lofc_pkg::LOFC_OPEN_USER) &&
			next_fb_ctrl[`LOFC_WAVE_SEL_BIT];
	end

	// mode registers and drive outputs
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			mode <= lofc_pkg::LOFC_CLOSED;
			miss_cnt <= 3'h0;
			o_open_loop <= 1'b0;
			o_sine <= 1'b0;
			o_fallback <= 1'b0;
		end else begin
			mode <= next_mode;
			miss_cnt <= next_miss_cnt;
			o_open_loop <= next_open_loop;
			o_fallback <= next_fallback;
			o_sine <= next_sine;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// period generator: unit prescaler then period counter
	localparam int UNIT_CYC = `LOFC_UNIT_CYCLES;
	logic [7:0] unit_cnt;
	logic [7:0] next_unit_cnt;
	logic [PERIOD_W-1:0] per_cnt;
	logic [PERIOD_W-1:0] next_per_cnt;
	logic next_tick;
	logic [PERIOD_W-1:0] period;

	assign period = PERIOD_W'({per_high[1:0], per_low});

	// counts only while open loop runs; a zero period gives no ticks
	always_comb begin
		next_unit_cnt = unit_cnt;
		next_per_cnt = per_cnt;
		next_tick = 1'b0;
		if (!o_open_loop || period == '0) begin
			next_unit_cnt = 8'h00;
			next_per_cnt = '0;
		end else if (unit_cnt == 8'(UNIT_CYC - 1)) begin
			next_unit_cnt = 8'h00;
			if (per_cnt >= period - 1'b1) begin
				next_per_cnt = '0;
				next_tick = 1'b1;
			end else
				next_per_cnt = per_cnt + 1'b1;
		end else
			next_unit_cnt = unit_cnt + 8'h01;
	end

	// period registers
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			unit_cnt <= 8'h00;
			per_cnt <= '0;
			o_period_tick <= 1'b0;
		end else begin
			unit_cnt <= next_unit_cnt;
			per_cnt <= next_per_cnt;
			o_period_tick <= next_tick;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	// fallback never drives a sine, whatever the select bit says
	fallback_square_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		o_fallback |-> !o_sine)
		else $error("sine driven during fallback");
	// the trip was decided with the enable set, even if it is cleared at that same edge
	fallback_entry_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		$rose(o_fallback) |-> $past(fb_en))
		else $error("fallback without enable");
	// the last allowed miss always trips the fallback on the next edge
	fallback_trip_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(mode == lofc_pkg::LOFC_CLOSED && fb_en && !i_open_loop_req && i_zc_attempt &&
		!i_zc_ok && miss_cnt == limit - 3'h1) |=> o_fallback)
		else $error("fallback missed its limit");
	// six is the largest setting, so the count never gets there; a lowered field may
	// leave the count above the new limit until the next attempt trips
	miss_bound_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		miss_cnt < 3'h6)
		else $error("miss count beyond limit");
	// a good crossing restarts the consecutive count
	miss_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(mode == lofc_pkg::LOFC_CLOSED && i_zc_attempt && i_zc_ok && !i_open_loop_req)
		|=> miss_cnt == 3'h0)
		else $error("good crossing kept misses");
	// a cleared enable ends any fallback on the next edge
	disable_exit_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		!fb_en |=> !o_fallback)
		else $error("fallback kept while disabled");
	// a cleared enable forgets the misses counted so far
	disable_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(mode == lofc_pkg::LOFC_CLOSED && !fb_en) |=> miss_cnt == 3'h0)
		else $error("misses kept while disabled");
	// user open loop takes its shape from the select bit
	sine_select_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(o_open_loop && !o_fallback) |-> o_sine == fb_ctrl[`LOFC_WAVE_SEL_BIT])
		else $error("shape differs from select");
	// a user request from closed loop opens the loop without a fallback flag
	user_open_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(mode == lofc_pkg::LOFC_CLOSED && i_open_loop_req) |=> (o_open_loop && !o_fallback))
		else $error("user request not followed");
	// only two period bits live in the high register
	high_bits_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		per_high[7:2] == 6'h00)
		else $error("period high reserved bits set");
	// a completed write to the low byte lands in the period register
	period_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0] &&
		i_avs_address == word_addr(`LOFC_IDX_PERIOD_LOW))
		|=> per_low == $past(i_avs_writedata[7:0]))
		else $error("period low write lost");
	// a tick is a single pulse
	tick_spacing_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		o_period_tick |=> !o_period_tick)
		else $error("period ticks adjacent");
	// ticks come only while the loop is open
	tick_open_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		o_period_tick |-> $past(o_open_loop))
		else $error("tick outside open loop");
	// a zero period gives no ticks at all
	zero_period_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(period == '0) |=> !o_period_tick)
		else $error("tick with zero period");
	// nothing but the load strobe changes the coefficient
	coef_ro_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		!i_coef_load |=> imp_coef == $past(imp_coef))
		else $error("coefficient changed");
	// the load strobe takes the trim value
	coef_load_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_coef_load |=> imp_coef == $past(i_coef_value))
		else $error("coefficient not loaded");

endmodule
`default_nettype wire

// file: rtl/lofc_defines.svh
// register offsets, field positions, reset values and timing counts of the open-loop control block
`ifndef LOFC_DEFINES_SVH
`define LOFC_DEFINES_SVH

// register indices; the bus byte address is four times the index
`define LOFC_IDX_FALLBACK_CTRL 8'h2C
`define LOFC_IDX_PERIOD_HIGH 8'h2E
`define LOFC_IDX_PERIOD_LOW 8'h2F
`define LOFC_IDX_IMP_COEF 8'h30

// control register fields
`define LOFC_FB_ENABLE_BIT 7
`define LOFC_MISS_CNT_HI 6
`define LOFC_MISS_CNT_LO 5
`define LOFC_WAVE_SEL_BIT 0

// reset values
`define LOFC_RST_FALLBACK_CTRL 8'h00
`define LOFC_RST_PERIOD_HIGH 8'h00
`define LOFC_RST_PERIOD_LOW 8'hC6
`define LOFC_RST_IMP_COEF 8'h00

// base miss count for field value 0
`define LOFC_MISS_BASE 3'h3

// period time unit, 24.39 us in picoseconds, and its cycle count rounded up at the system clock
`define LOFC_UNIT_PS 24390000
`define LOFC_CLK_PERIOD_PS 100000
`define LOFC_UNIT_CYCLES ((`LOFC_UNIT_PS + `LOFC_CLK_PERIOD_PS - 1) / `LOFC_CLK_PERIOD_PS)

`endif

// file: rtl/lofc_pkg.sv
// types shared by the open-loop control block
package lofc_pkg;
	// drive mode of the actuator
	typedef enum logic [1:0] {
		LOFC_CLOSED = 2'b00,
		LOFC_OPEN_USER = 2'b10,
		LOFC_OPEN_FALLBACK = 2'b01
	} lofc_mode_t;
endpackage

// file: test/lofc_host.sv
// avalon-mm host model that issues register accesses to the open-loop control block
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
module lofc_host (
	input wire logic i_sys_clk, // system clock
	input wire logic [31:0] i_avs_readdata, // read data from the block
	input wire logic i_avs_waitrequest, // slave stall
	output logic [7:0] o_avs_address, // byte address
	output logic o_avs_read, // read request
	output logic o_avs_write, // write request
	output logic [31:0] o_avs_writedata, // write data
	output logic [3:0] o_avs_byteenable // byte lanes
);
	// idle bus at time zero; lane 0 only, the block ignores the rest
	initial begin
		o_avs_address = 8'h00;
		o_avs_read = 1'b0;
		o_avs_write = 1'b0;
		o_avs_writedata = 32'h0000_0000;
		o_avs_byteenable = 4'h1;
	end
	// one access: hold everything until waitrequest is seen low, no latency assumed
	task automatic xfer(input logic [7:0] a, input logic wr, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge i_sys_clk);
		o_avs_address <= a;
		o_avs_read <= ~wr;
		o_avs_write <= wr;
		o_avs_writedata <= {24'h00_0000, d};
		@(posedge i_sys_clk);
		while (i_avs_waitrequest !== 1'b0) @(posedge i_sys_clk);
		q = i_avs_readdata[7:0];
		o_avs_read <= 1'b0;
		o_avs_write <= 1'b0;
	endtask
endmodule
`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the open-loop fallback control block
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
module testbench;
	logic i_sys_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic [7:0] addr;
	logic rd, wr;
	logic [31:0] wdata, rdata;
	logic [3:0] be;
	logic wait_req, open_req = 1'b0, zc_att = 1'b0, zc_ok = 1'b0, stop = 1'b0;
	logic [7:0] coef = 8'h00;
	logic coef_ld = 1'b0;
	logic open_loop, sine, fb, tick;
	logic [7:0] q;
	int n_fail = 0, checked = 0, n;
	// 10 MHz clock
	always #50 i_sys_clk = ~i_sys_clk;
	lofc_host i_host (.i_sys_clk(i_sys_clk), .i_avs_readdata(rdata), .i_avs_waitrequest(wait_req),
		.o_avs_address(addr), .o_avs_read(rd), .o_avs_write(wr), .o_avs_writedata(wdata),
		.o_avs_byteenable(be));
	lofc_ctrl i_dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_avs_address(addr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_open_loop_req(open_req),
		.i_zc_attempt(zc_att), .i_zc_ok(zc_ok), .i_drive_stop(stop), .i_coef_value(coef),
		.i_coef_load(coef_ld), .o_open_loop(open_loop), .o_sine(sine), .o_fallback(fb),
		.o_period_tick(tick));
	////////////////////////////////////////////////////////////////
	// compare, count and report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checked %0d, n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		i_host.xfer(a, 1'b1, d, q);
	endtask
	task automatic rd_reg(input logic [7:0] a);
		i_host.xfer(a, 1'b0, 8'h00, q);
	endtask
	// n detection attempts back to back, then let the outputs settle
	task automatic zc(input int cnt, input logic ok);
		repeat (cnt) begin
			@(posedge i_sys_clk);
			zc_att <= 1'b1;
			zc_ok <= ok;
		end
		@(posedge i_sys_clk);
		zc_att <= 1'b0;
		zc_ok <= 1'b0;
		repeat (3) @(posedge i_sys_clk);
	endtask
	// cycles from here to the next period tick, bounded
	task automatic tick_gap();
		n = 0;
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (tick !== 1'b1 && n < 70000);
	endtask
	////////////////////////////////////////////////////////////////
	// watchdog: one long period of about 63 thousand cycles dominates the run
	initial begin
		#8_000_000;
		n_fail++;
		print_verdict();
	end
	// main sequence
	initial begin
		repeat (4) @(posedge i_sys_clk);
		i_rstn <= 1'b1;
		rd_reg(8'hB0); chk(q, 8'h00);
		rd_reg(8'hB8); chk(q, 8'h00);
		rd_reg(8'hBC); chk(q, 8'hC6);
		rd_reg(8'hC0); chk(q, 8'h00);
		// coefficient is loaded from trim side only; a bus write must not land
		@(posedge i_sys_clk);
		coef <= 8'h5A;
		coef_ld <= 1'b1;
		@(posedge i_sys_clk);
		coef_ld <= 1'b0;
		wr_reg(8'hC0, 8'hFF);
		rd_reg(8'hC0); chk(q, 8'h5A);
		rd_reg(8'h04); chk(q, 8'h00);
		wr_reg(8'hB8, 8'hFF);
		rd_reg(8'hB8); chk(q, 8'h03);
		// period 258 spans both registers; one unit is 24.39 us, 244 cycles rounded up
		wr_reg(8'hB8, 8'h01);
		wr_reg(8'hBC, 8'h02);
		wr_reg(8'hB0, 8'h01);
		// first tick: one cycle to open the loop, one more for the registered tick
		@(posedge i_sys_clk);
		open_req <= 1'b1;
		tick_gap();
		chk(n, 258 * 244 + 2);
		chk(open_loop, 1'b1);
		chk(sine, 1'b1);
		// period 2 now; time one whole gap between two ticks
		wr_reg(8'hB8, 8'h00);
		tick_gap();
		tick_gap();
		chk(n, 2 * 244);
		wr_reg(8'hB0, 8'h00);
		repeat (2) @(posedge i_sys_clk);
		chk(sine, 1'b0);
		open_req <= 1'b0;
		// every miss count; a success in between restarts the count
		for (int f = 0; f < 4; f++) begin
			wr_reg(8'hB0, 8'(8'h81 | (f << 5)));
			zc(2 + f, 1'b0);
			zc(1, 1'b1);
			zc(2 + f, 1'b0);
			chk(fb, 1'b0);
			zc(1, 1'b0);
			chk(fb, 1'b1);
			chk(open_loop, 1'b1);
			chk(sine, 1'b0);
			@(posedge i_sys_clk);
			stop <= 1'b1;
			@(posedge i_sys_clk);
			stop <= 1'b0;
			repeat (2) @(posedge i_sys_clk);
			chk(fb, 1'b0);
		end
		// clearing the enable also ends a fallback
		wr_reg(8'hB0, 8'h80);
		zc(3, 1'b0);
		chk(fb, 1'b1);
		wr_reg(8'hB0, 8'h00);
		repeat (2) @(posedge i_sys_clk);
		chk(fb, 1'b0);
		chk(open_loop, 1'b0);
		wr_reg(8'hB0, 8'h60);
		zc(8, 1'b0);
		chk(fb, 1'b0);
		chk(open_loop, 1'b0);
		print_verdict();
	end
endmodule
`default_nettype wire
